// ### evt_source.sv
// partner model: interrupt source that holds its request until taken
`timescale 1ns/10ps
module evt_source (
    input  wire logic clk_sys_in,
    input  wire logic srst_in,
    input  wire logic req_in,
    input  wire logic busy_in,
    output logic      valid_out
);
    always_ff @(posedge clk_sys_in)
        if (srst_in || busy_in) valid_out <= 1'b0;
        else if (req_in) valid_out <= 1'b1;
endmodule // evt_source

// ### lm_int_defs.svh
// named offsets, field positions and sizes for the long-mode interrupt entry unit
`ifndef LM_INT_DEFS_SVH
`define LM_INT_DEFS_SVH

`define LM_ADDR_W         8
`define LM_CTRL_OFF       8'h00
`define LM_PRIO_OFF       8'h04
`define LM_STAT_OFF       8'h08
`define LM_TABLE_BASE     8'h40
`define LM_TABLE_END      8'h8C
`define LM_TABLE_ENTRIES  10
`define LM_IDX_W          4
`define LM_IST_BASE       4'h3
`define LM_CTRL_LONG_BIT  0
`define LM_CTRL_COMPAT_BIT 1
`define LM_PRIO_W         4
`define LM_STAT_BUSY_BIT  0
`define LM_STAT_HELD_BIT  1
`define LM_STAT_GP_BIT    2
`define LM_STAT_VEC_LSB   8
`define LM_SHIFT_LONG     4
`define LM_SHIFT_LEGACY   3
`define LM_OFFSET_W       12
`define LM_PUSH_LONG      4'h8
`define LM_PUSH_GATE32    4'h4
`define LM_PUSH_GATE16    4'h2
`define LM_POP_NARROW     4'h4
`define LM_USER_CPL       2'h3
`define LM_RESP_OKAY      2'b00
`define LM_RESP_SLVERR    2'b10

`endif

// ### lm_int_pkg.sv
// types shared by the long-mode interrupt entry unit
package lm_int_pkg;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_READ = 2'b01,
        ST_DONE = 2'b10
    } entry_state_e;

    typedef enum logic [1:0] {
        GATE_INTR = 2'b00,
        GATE_TRAP = 2'b01,
        GATE_TASK = 2'b10
    } gate_e;
endpackage

// ### long_mode_interrupt_entry.sv
// interrupt entry and return decisions for long and legacy mode, with AXI4-Lite registers
//
// Implementation choices: the address map and the AXI4-Lite slave port.
`timescale 1ns/10ps
`include "lm_int_defs.svh"
// How it works
// - long-mode interrupts always enter 64-bit mode
// - long mode: descriptor offset is vector times 16
// - legacy mode: descriptor offset is vector times eight
// - task gate in long mode raises protection fault
// - long-mode frame pushes are eight bytes each
// - long mode always pushes old stack pair
// - legacy push width from gate; pair on change
// - privilege change loads full 64-bit stack pointer
// - long-mode privilege change loads null selector, privilege field 0
// - old stack pair written onto new stack
// - alternate stack enabled: always switch to it
// - alternate stacks from structure, long mode only
// - compatibility return pops pair only on change
// - 64-bit return always pops stack pair
// - long mode: null selector popped only to 64-bit, level<3
// - fifteen priority classes, one lowest, fifteen highest
// - priority field is four low register bits
module long_mode_interrupt_entry (
    input  wire logic                    clk_sys_in,
    input  wire logic                    srst_in,
    input  wire logic [`LM_ADDR_W-1:0]   awaddr_in,
    input  wire logic                    awvalid_in,
    output logic                         awready_out,
    input  wire logic [31:0]             wdata_in,
    input  wire logic [3:0]              wstrb_in,
    input  wire logic                    wvalid_in,
    output logic                         wready_out,
    output logic [1:0]                   bresp_out,
    output logic                         bvalid_out,
    input  wire logic                    bready_in,
    input  wire logic [`LM_ADDR_W-1:0]   araddr_in,
    input  wire logic                    arvalid_in,
    output logic                         arready_out,
    output logic [31:0]                  rdata_out,
    output logic [1:0]                   rresp_out,
    output logic                         rvalid_out,
    input  wire logic                    rready_in,
    input  wire logic                    evt_valid_in,
    input  wire logic [7:0]              evt_vector_in,
    input  wire lm_int_pkg::gate_e       evt_gate_in,
    input  wire logic                    evt_gate32_in,
    input  wire logic [2:0]              evt_ist_in,
    input  wire logic [1:0]              evt_cpl_in,
    input  wire logic [1:0]              evt_dpl_in,
    input  wire logic                    evt_external_in,
    input  wire logic [`LM_PRIO_W-1:0]   evt_class_in,
    output logic                         evt_busy_out,
    output logic                         ext_held_out,
    output logic                         res_valid_out,
    output logic [`LM_OFFSET_W-1:0]      res_offset_out,
    output logic [3:0]                   res_push_bytes_out,
    output logic                         res_push_stack_out,
    output logic                         res_switch_out,
    output logic [63:0]                  res_sp_out,
    output logic                         res_null_ss_out,
    output logic [1:0]                   res_ss_rpl_out,
    output logic                         res_mode64_out,
    output logic                         res_gp_out,
    input  wire logic                    ret_valid_in,
    input  wire logic                    ret_wide_in,
    input  wire logic                    ret_cpl_change_in,
    input  wire logic                    ret_target64_in,
    input  wire logic [1:0]              ret_target_cpl_in,
    input  wire logic                    ret_ss_null_in,
    output logic                         ret_done_out,
    output logic                         ret_pop_stack_out,
    output logic [3:0]                   ret_pop_bytes_out,
    output logic                         ret_gp_out
);
    stack_table_if tbl ();

    stack_table_mem #(.DEPTH(`LM_TABLE_ENTRIES)) u_table (
        .clk_sys_in (clk_sys_in),
        .port_io    (tbl.table_side)
    );

    function automatic logic in_table(input logic [`LM_ADDR_W-1:0] a);
        return (a >= `LM_TABLE_BASE) && (a <= `LM_TABLE_END) && (a[1:0] == 2'b00);
    endfunction

    function automatic logic is_mapped(input logic [`LM_ADDR_W-1:0] a);
        return in_table(a) || a == `LM_CTRL_OFF || a == `LM_PRIO_OFF || a == `LM_STAT_OFF;
    endfunction

    // ---------------- register bus ----------------
    logic                   have_aw, next_have_aw, have_w, next_have_w;
    logic [`LM_ADDR_W-1:0]  aw_addr, next_aw_addr;
    logic [31:0]            w_data, next_w_data;
    logic [3:0]             w_strb, next_w_strb;
    logic                   next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
    logic [1:0]             next_bresp, next_rresp;
    logic [31:0]            next_rdata;
    logic                   ctrl_long, next_ctrl_long, ctrl_compat, next_ctrl_compat;
    logic [`LM_PRIO_W-1:0]  prio, next_prio;
    logic                   last_gp, next_last_gp;
    logic [7:0]             last_vec, next_last_vec;
    logic                   do_write;
    logic [`LM_ADDR_W-1:0]  tbl_off;

    always_comb begin
        next_have_aw = have_aw;
        next_aw_addr = aw_addr;
        next_have_w  = have_w;
        next_w_data  = w_data;
        next_w_strb  = w_strb;
        next_bvalid  = bvalid_out && !bready_in;
        next_bresp   = bresp_out;
        next_ctrl_long   = ctrl_long;
        next_ctrl_compat = ctrl_compat;
        next_prio    = prio;
        if (awvalid_in && awready_out) begin
            next_have_aw = 1'b1;
            next_aw_addr = awaddr_in;
        end
        if (wvalid_in && wready_out) begin
            next_have_w = 1'b1;
            next_w_data = wdata_in;
            next_w_strb = wstrb_in;
        end
        do_write = have_aw && have_w && !bvalid_out;
        if (do_write) begin
            next_have_aw = 1'b0;
            next_have_w  = 1'b0;
            next_bvalid  = 1'b1;
            next_bresp   = is_mapped(aw_addr) ? `LM_RESP_OKAY : `LM_RESP_SLVERR;
            if (aw_addr == `LM_CTRL_OFF && w_strb[0]) begin
                next_ctrl_long   = w_data[`LM_CTRL_LONG_BIT];
                next_ctrl_compat = w_data[`LM_CTRL_COMPAT_BIT];
            end
            if (aw_addr == `LM_PRIO_OFF && w_strb[0]) begin
                next_prio = w_data[`LM_PRIO_W-1:0];
            end
        end
        next_awready = !next_have_aw && !next_bvalid;
        next_wready  = !next_have_w && !next_bvalid;
    end

    assign tbl_off     = aw_addr - `LM_TABLE_BASE;
    assign tbl.wr_en   = do_write && in_table(aw_addr);
    assign tbl.wr_hi   = tbl_off[2];
    assign tbl.wr_idx  = tbl_off[`LM_IDX_W+2:3];
    assign tbl.wr_data = w_data;
    assign tbl.wr_strb = w_strb;

    always_comb begin
        next_rvalid  = rvalid_out && !rready_in;
        next_rdata   = rdata_out;
        next_rresp   = rresp_out;
        if (arvalid_in && arready_out) begin
            next_rvalid = 1'b1;
            next_rresp  = is_mapped(araddr_in) ? `LM_RESP_OKAY : `LM_RESP_SLVERR;
            next_rdata  = 32'h0000_0000;
            // the table is write-only; its words read back as zero
            unique case (araddr_in)
                `LM_CTRL_OFF: begin
                    next_rdata[`LM_CTRL_LONG_BIT]   = ctrl_long;
                    next_rdata[`LM_CTRL_COMPAT_BIT] = ctrl_compat;
                end
                `LM_PRIO_OFF: next_rdata[`LM_PRIO_W-1:0] = prio;
                `LM_STAT_OFF: begin
                    next_rdata[`LM_STAT_BUSY_BIT] = evt_busy_out;
                    next_rdata[`LM_STAT_HELD_BIT] = ext_held_out;
                    next_rdata[`LM_STAT_GP_BIT]   = last_gp;
                    next_rdata[`LM_STAT_VEC_LSB +: 8] = last_vec;
                end
                default: next_rdata = 32'h0000_0000;
            endcase
        end
        next_arready = !next_rvalid;
    end

    // ---------------- interrupt entry ----------------
    lm_int_pkg::entry_state_e state, next_state;
    logic [7:0]     cap_vec, next_cap_vec;
    lm_int_pkg::gate_e cap_gate, next_cap_gate;
    logic           cap_g32, next_cap_g32, cap_chg, next_cap_chg, cap_long, next_cap_long;
    logic [2:0]     cap_ist, next_cap_ist;
    logic [1:0]     cap_dpl, next_cap_dpl;
    logic           evt_hold, evt_take, gp, sw;
    logic           next_busy, next_held, next_res_valid, next_res_push, next_res_switch;
    logic           next_res_null, next_res_mode64, next_res_gp;
    logic [`LM_OFFSET_W-1:0] next_res_offset;
    logic [3:0]     next_res_bytes;
    logic [63:0]    next_res_sp;

    // class zero is no class, so it is never above the field
    assign evt_hold = evt_external_in && (evt_class_in <= prio);
    assign evt_take = (state == lm_int_pkg::ST_IDLE) && evt_valid_in && !evt_hold;

    // alternate stacks only in long mode
    // privilege stack indexed by target level
    assign tbl.rd_idx = (cap_long && cap_ist != 3'h0) ?
                        `LM_IST_BASE + {1'b0, cap_ist} - 4'h1 : {2'b00, cap_dpl};

    always_comb begin
        next_state    = state;
        next_cap_vec  = cap_vec;
        next_cap_gate = cap_gate;
        next_cap_g32  = cap_g32;
        next_cap_chg  = cap_chg;
        next_cap_long = cap_long;
        next_cap_ist  = cap_ist;
        next_cap_dpl  = cap_dpl;
        next_held     = evt_valid_in && (state == lm_int_pkg::ST_IDLE) && evt_hold;
        next_last_gp  = last_gp;
        next_last_vec = last_vec;
        next_res_valid = 1'b0;
        gp = cap_long && cap_gate == lm_int_pkg::GATE_TASK;
        sw = !gp && ((cap_long && cap_ist != 3'h0) || cap_chg);
        next_res_offset = cap_long ? `LM_OFFSET_W'(cap_vec) << `LM_SHIFT_LONG
                                   : `LM_OFFSET_W'(cap_vec) << `LM_SHIFT_LEGACY;
        next_res_bytes  = cap_long ? `LM_PUSH_LONG
                                   : (cap_g32 ? `LM_PUSH_GATE32 : `LM_PUSH_GATE16);
        next_res_push   = !gp && (cap_long || cap_chg);
        next_res_switch = sw;
        next_res_sp     = sw ? tbl.rd_data : 64'h0000_0000_0000_0000;
        next_res_null   = !gp && cap_long && cap_chg;
        next_res_mode64 = cap_long;
        next_res_gp     = gp;
        unique case (state)
            lm_int_pkg::ST_IDLE: begin
                if (evt_take) begin
                    next_state    = lm_int_pkg::ST_READ;
                    next_cap_vec  = evt_vector_in;
                    next_cap_gate = evt_gate_in;
                    next_cap_g32  = evt_gate32_in;
                    next_cap_chg  = evt_cpl_in != evt_dpl_in;
                    next_cap_long = ctrl_long;
                    next_cap_ist  = evt_ist_in;
                    next_cap_dpl  = evt_dpl_in;
                end
            end
            lm_int_pkg::ST_READ: next_state = lm_int_pkg::ST_DONE;
            lm_int_pkg::ST_DONE: begin
                next_state     = lm_int_pkg::ST_IDLE;
                next_res_valid = 1'b1;
                next_last_gp   = gp;
                next_last_vec  = cap_vec;
            end
            default: next_state = lm_int_pkg::ST_IDLE;
        endcase
        next_busy = next_state != lm_int_pkg::ST_IDLE;
    end

    // ---------------- interrupt return ----------------
    logic mode64, next_ret_pop, next_ret_gp;
    logic [3:0] next_ret_bytes;
    always_comb begin
        mode64 = ctrl_long && !ctrl_compat;
        next_ret_pop = ret_valid_in && (mode64 || ret_cpl_change_in);
        next_ret_bytes = (mode64 && ret_wide_in) ? `LM_PUSH_LONG : `LM_POP_NARROW;
        next_ret_gp = next_ret_pop && ctrl_long && ret_ss_null_in &&
                      !(ret_target64_in && ret_target_cpl_in < `LM_USER_CPL);
    end

    always_ff @(posedge clk_sys_in) begin
        if (srst_in) begin
            have_aw <= 1'b0;  aw_addr <= '0;  have_w <= 1'b0;
            w_data <= '0;  w_strb <= '0;
            awready_out <= 1'b1;  wready_out <= 1'b1;
            bvalid_out <= 1'b0;  bresp_out <= `LM_RESP_OKAY;
            arready_out <= 1'b1;  rvalid_out <= 1'b0;
            rdata_out <= '0;  rresp_out <= `LM_RESP_OKAY;
            ctrl_long <= 1'b0;  ctrl_compat <= 1'b0;  prio <= '0;
            last_gp <= 1'b0;  last_vec <= '0;
            state <= lm_int_pkg::ST_IDLE;
            cap_vec <= '0;  cap_gate <= lm_int_pkg::GATE_INTR;  cap_g32 <= 1'b0;
            cap_chg <= 1'b0;  cap_long <= 1'b0;  cap_ist <= '0;  cap_dpl <= '0;
            evt_busy_out <= 1'b0;  ext_held_out <= 1'b0;
            res_valid_out <= 1'b0;  res_offset_out <= '0;  res_push_bytes_out <= '0;
            res_push_stack_out <= 1'b0;  res_switch_out <= 1'b0;  res_sp_out <= '0;
            res_null_ss_out <= 1'b0;  res_ss_rpl_out <= 2'b00;
            res_mode64_out <= 1'b0;  res_gp_out <= 1'b0;
            ret_done_out <= 1'b0;  ret_pop_stack_out <= 1'b0;
            ret_pop_bytes_out <= '0;  ret_gp_out <= 1'b0;
        end else begin
            have_aw <= next_have_aw;  aw_addr <= next_aw_addr;  have_w <= next_have_w;
            w_data <= next_w_data;  w_strb <= next_w_strb;
            awready_out <= next_awready;  wready_out <= next_wready;
            bvalid_out <= next_bvalid;  bresp_out <= next_bresp;
            arready_out <= next_arready;  rvalid_out <= next_rvalid;
            rdata_out <= next_rdata;  rresp_out <= next_rresp;
            ctrl_long <= next_ctrl_long;  ctrl_compat <= next_ctrl_compat;  prio <= next_prio;
            last_gp <= next_last_gp;  last_vec <= next_last_vec;
            state <= next_state;
            cap_vec <= next_cap_vec;  cap_gate <= next_cap_gate;  cap_g32 <= next_cap_g32;
            cap_chg <= next_cap_chg;  cap_long <= next_cap_long;
            cap_ist <= next_cap_ist;  cap_dpl <= next_cap_dpl;
            evt_busy_out <= next_busy;  ext_held_out <= next_held;
            res_valid_out <= next_res_valid;
            if (next_res_valid) begin
                res_offset_out <= next_res_offset;  res_push_bytes_out <= next_res_bytes;
                res_push_stack_out <= next_res_push;  res_switch_out <= next_res_switch;
                res_sp_out <= next_res_sp;  res_null_ss_out <= next_res_null;
                res_ss_rpl_out <= 2'b00;
                res_mode64_out <= next_res_mode64;  res_gp_out <= next_res_gp;
            end
            ret_done_out <= ret_valid_in;  ret_pop_stack_out <= next_ret_pop;
            ret_pop_bytes_out <= next_ret_bytes;  ret_gp_out <= next_ret_gp;
        end
    end

    // ---------------- checks ----------------
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (srst_in);

    sequence take_long_s;  evt_take && ctrl_long;  endsequence
    sequence take_legacy_s;  evt_take && !ctrl_long;  endsequence

    entry_mode64_a: assert property (take_long_s |-> ##3 (res_valid_out && res_mode64_out))
        else $error("long-mode entry did not enter 64-bit mode");
    long_offset_a: assert property (take_long_s |-> ##3
            res_offset_out == {$past(evt_vector_in, 3), 4'h0})
        else $error("long-mode offset is not vector times 16");
    legacy_offset_a: assert property (take_legacy_s |-> ##3
            res_offset_out == {1'b0, $past(evt_vector_in, 3), 3'h0})
        else $error("legacy offset is not vector times 8");
    task_gate_gp_a: assert property (take_long_s ##0 evt_gate_in == lm_int_pkg::GATE_TASK
            |-> ##3 (res_gp_out && !res_switch_out && !res_push_stack_out))
        else $error("task gate in long mode did not fault");
    push_width_a: assert property (take_long_s |-> ##3
            (res_push_bytes_out == 4'h8 && (res_gp_out || res_push_stack_out)))
        else $error("long-mode push width or stack pair wrong");
    null_ss_a: assert property (take_long_s ##0 (evt_cpl_in != evt_dpl_in &&
            evt_gate_in != lm_int_pkg::GATE_TASK) |-> ##3
            (res_null_ss_out && res_ss_rpl_out == 2'b00 && res_switch_out))
        else $error("privilege change did not load null selector");
    ist_switch_a: assert property (take_legacy_s ##0 (evt_cpl_in == evt_dpl_in)
            |-> ##3 (!res_switch_out && !res_push_stack_out))
        else $error("alternate stack used outside long mode");
    ret_pop_a: assert property ((ret_valid_in && ctrl_long && !ctrl_compat)
            |=> (ret_done_out && ret_pop_stack_out))
        else $error("64-bit return did not pop the stack pair");
    ret_null_a: assert property ((ret_valid_in && ctrl_long && ret_ss_null_in &&
            ret_target64_in && ret_target_cpl_in == 2'h3) |=> ret_gp_out == ret_pop_stack_out)
        else $error("null selector accepted for level three");
    ext_hold_a: assert property ((state == lm_int_pkg::ST_IDLE && evt_valid_in && evt_hold)
            |=> (ext_held_out && !evt_busy_out) ##1 !res_valid_out)
        else $error("held-off class was delivered");
endmodule // long_mode_interrupt_entry

// ### long_mode_interrupt_entry_bench.sv
// self-checking bench for the long-mode interrupt entry unit
`timescale 1ns/10ps
module long_mode_interrupt_entry_bench;
    logic clk_sys_in = 0, srst_in = 1, awvalid_in = 0, wvalid_in = 0, bready_in = 0, req = 0;
    logic arvalid_in = 0, rready_in = 0, evt_gate32_in = 0, evt_external_in = 0;
    logic ret_valid_in = 0, ret_wide_in = 0, ret_cpl_change_in = 0, ret_target64_in = 0;
    logic ret_ss_null_in = 0, evt_valid_in, awready_out, wready_out, bvalid_out, arready_out;
    logic rvalid_out, evt_busy_out, ext_held_out, res_valid_out, res_push_stack_out;
    logic res_switch_out, res_null_ss_out, res_mode64_out, res_gp_out, ret_done_out;
    logic ret_pop_stack_out, ret_gp_out;
    logic [7:0] awaddr_in = 0, araddr_in = 0, evt_vector_in = 0;
    logic [31:0] wdata_in = 0, rdata_out;
    logic [3:0] wstrb_in = 4'hF, evt_class_in = 0, res_push_bytes_out, ret_pop_bytes_out;
    logic [2:0] evt_ist_in = 0;
    logic [1:0] evt_cpl_in = 0, evt_dpl_in = 0, ret_target_cpl_in = 0, bresp_out, rresp_out;
    logic [1:0] res_ss_rpl_out, wresp;
    logic [11:0] res_offset_out;
    logic [63:0] res_sp_out;
    lm_int_pkg::gate_e evt_gate_in = lm_int_pkg::GATE_INTR;
    int n_errors = 0, n_tests = 0;
    wire [22:0] res_all = {res_offset_out, res_push_bytes_out, res_push_stack_out,
        res_switch_out, res_null_ss_out, res_mode64_out, res_gp_out, res_ss_rpl_out};
    long_mode_interrupt_entry dut (.*);
    evt_source src (.clk_sys_in, .srst_in, .req_in(req), .busy_in(evt_busy_out),
        .valid_out(evt_valid_in));
    always #5 clk_sys_in = ~clk_sys_in;
    task chk(input logic [63:0] g, e);
        n_tests++;
        if (g !== e) begin
            n_errors++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    // readies are registered, so releasing at the taking edge never double-sends
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys_in);
        awaddr_in <= a;
        wdata_in <= d;
        awvalid_in <= 1;
        wvalid_in <= 1;
        bready_in <= 1;
        do begin
            @(posedge clk_sys_in);
            if (awready_out) awvalid_in <= 0;
            if (wready_out) wvalid_in <= 0;
        end while (bvalid_out !== 1'b1);
        wresp = bresp_out;
        bready_in <= 0;
    endtask
    task rd(input logic [7:0] a, output logic [33:0] rr);
        @(posedge clk_sys_in);
        araddr_in <= a;
        arvalid_in <= 1;
        rready_in <= 1;
        do begin
            @(posedge clk_sys_in);
            if (arready_out) arvalid_in <= 0;
        end while (rvalid_out !== 1'b1);
        rr = {rresp_out, rdata_out};
        rready_in <= 0;
    endtask
    task ent(input logic [7:0] v, input logic [1:0] c, d, input logic [2:0] s = 0,
        input lm_int_pkg::gate_e g = lm_int_pkg::GATE_INTR, input logic x = 0,
        input logic [3:0] k = 0);
        @(posedge clk_sys_in);
        evt_vector_in <= v;
        evt_cpl_in <= c;
        evt_dpl_in <= d;
        evt_ist_in <= s;
        evt_gate_in <= g;
        evt_external_in <= x;
        evt_class_in <= k;
        req <= 1;
        @(posedge clk_sys_in);
        req <= 0;
    endtask
    task wres;
        for (int i = 0; i < 40 && res_valid_out !== 1'b1; i++) @(negedge clk_sys_in);
        chk(res_valid_out, 1);
    endtask
    task ret(input logic w, c, t, input logic [1:0] l, input logic n, input logic [6:0] e);
        @(posedge clk_sys_in);
        {ret_wide_in, ret_cpl_change_in, ret_target64_in, ret_target_cpl_in} <= {w, c, t, l};
        ret_ss_null_in <= n;
        ret_valid_in <= 1;
        @(posedge clk_sys_in);
        ret_valid_in <= 0;
        @(negedge clk_sys_in);
        chk({ret_done_out, ret_pop_stack_out, ret_pop_bytes_out, ret_gp_out}, e);
    endtask
    task t_long;
        wr(8'h40, 32'h1111_2220);
        wr(8'h44, 32'hAAAA_0000);
        wr(8'h60, 32'h3333_4440);
        wr(8'h64, 32'h5);
        wr(8'h00, 32'h1);
        chk(wresp, 2'b00);
        ent(8'h05, 0, 0);
        wres;
        chk(res_all, {12'h050, 4'h8, 5'b10010, 2'h0});
        ent(8'hFF, 3, 0);
        wres;
        chk(res_all, {12'hFF0, 4'h8, 5'b11110, 2'h0});
        chk(res_sp_out, 64'hAAAA_0000_1111_2220);
        ent(8'h02, 0, 0, 2);
        wres;
        chk(res_sp_out, 64'h5_3333_4440);
        ent(8'h03, 0, 0, 0, lm_int_pkg::GATE_TASK);
        wres;
        chk(res_gp_out, 1);
        $display("long entry test done");
    endtask
    task t_legacy;
        wr(8'h00, 32'h0);
        evt_gate32_in <= 1;
        ent(8'hFF, 0, 0, 2);
        wres;
        chk(res_all, {12'h7F8, 4'h4, 5'b0, 2'h0});
        evt_gate32_in <= 0;
        ent(8'h01, 0, 0);
        wres;
        chk(res_all, {12'h008, 4'h2, 5'b0, 2'h0});
        $display("legacy entry test done");
    endtask
    task t_ret;
        wr(8'h00, 32'h1);
        ret(1, 0, 1, 0, 0, 7'h70);
        ret(1, 0, 1, 3, 1, 7'h71);
        ret(1, 0, 1, 2, 1, 7'h70);
        ret(1, 0, 0, 0, 1, 7'h71);
        wr(8'h00, 32'h3);
        ret(0, 0, 1, 0, 0, 7'h48);
        ret(0, 1, 1, 0, 0, 7'h68);
        $display("return test done");
    endtask
    task t_prio;
        logic [33:0] rr;
        wr(8'h04, 32'hF4);
        rd(8'h04, rr);
        chk(rr, 34'h4);
        ent(8'h20, 0, 0, 0, lm_int_pkg::GATE_INTR, 1, 4'h4);
        repeat (4) @(negedge clk_sys_in);
        chk({ext_held_out, evt_busy_out, res_valid_out}, 3'b100);
        wr(8'h04, 32'h0);
        wres;
        ent(8'h21, 0, 0, 0, lm_int_pkg::GATE_INTR, 1, 4'h1);
        wres;
        rd(8'h10, rr);
        chk(rr[33:32], 2'b10);
        wr(8'h10, 32'h1);
        chk(wresp, 2'b10);
        $display("priority test done");
    endtask
    task t_reset;
        logic [33:0] rr;
        wr(8'h04, 32'h9);
        srst_in <= 1;
        repeat (2) @(posedge clk_sys_in);
        srst_in <= 0;
        @(negedge clk_sys_in);
        chk({awready_out, wready_out, arready_out, bvalid_out, rvalid_out, evt_busy_out,
            ext_held_out, ret_done_out}, 8'hE0);
        chk(res_all, 23'h0);
        rd(8'h00, rr);
        chk(rr, 34'h0);
        rd(8'h04, rr);
        chk(rr, 34'h0);
        $display("reset test done");
    endtask
    task complete_run;
        $display("comparisons %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge clk_sys_in);
        srst_in <= 0;
        t_long;
        t_legacy;
        t_ret;
        t_prio;
        t_reset;
        complete_run;
    end
    // whole run needs well under a thousand cycles
    initial begin
        #100000;
        n_errors++;
        complete_run;
    end
endmodule // long_mode_interrupt_entry_bench

// ### stack_table_if.sv
// carrier between the entry logic and its stack pointer table
`timescale 1ns/10ps
`include "lm_int_defs.svh"
interface stack_table_if;
    logic                  wr_en;
    logic                  wr_hi;
    logic [`LM_IDX_W-1:0]  wr_idx;
    logic [31:0]           wr_data;
    logic [3:0]            wr_strb;
    logic [`LM_IDX_W-1:0]  rd_idx;
    logic [63:0]           rd_data;

    modport table_side (input wr_en, wr_hi, wr_idx, wr_data, wr_strb, rd_idx, output rd_data);
    modport user_side  (output wr_en, wr_hi, wr_idx, wr_data, wr_strb, rd_idx, input rd_data);
endinterface

// ### stack_table_mem.sv
// stack pointer table: three privilege stacks then seven alternate stacks
`timescale 1ns/10ps
`include "lm_int_defs.svh"
module stack_table_mem #(
    parameter int DEPTH = `LM_TABLE_ENTRIES
) (
    input  wire logic          clk_sys_in,
    stack_table_if.table_side  port_io
);
    logic [63:0] mem [DEPTH];

    // one process owns the whole array; per-lane processes would be rival drivers of mem
    always_ff @(posedge clk_sys_in) begin
        if (port_io.wr_en) begin
            for (int b = 0; b < 4; b++) begin
                if (port_io.wr_strb[b]) begin
                    if (port_io.wr_hi) begin
                        mem[port_io.wr_idx][32+8*b +: 8] <= port_io.wr_data[8*b +: 8];
                    end else begin
                        mem[port_io.wr_idx][8*b +: 8] <= port_io.wr_data[8*b +: 8];
                    end
                end
            end
        end
    end

    // read data registered: one cycle after the index is presented
    always_ff @(posedge clk_sys_in) begin
        port_io.rd_data <= mem[port_io.rd_idx];
    end
endmodule // stack_table_mem
